// [core/scic_channel.sv]
// two-wire channel: condition generator, ack drive, clock hold and event flags
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RULE1] Master writing start_request makes the channel generate a start condition.
// [RULE2] Master writing restart_request makes the channel generate a repeated start.
// [RULE3] Master writing stop_request makes the channel generate a stop condition.
// [RULE4] Conditions reach the lines only while condition_output_select is one.
// [RULE5] acknowledge_output drives acknowledge_value onto the data line in the ack slot.
// [RULE6] With clock_stop_on_stop set, clock output stops once a stop is seen.
// [RULE7] ninth_bit_clock_hold holds clock low from the ninth clock's falling edge.
// [RULE8] data_delay_field sets the digital delay of the data output.
// [RULE9] Two-wire mode needs mode field 010b and two_wire_enable one.
// [RULE10] Start-condition detection raises the bus-condition event.
// [RULE11] Transmit event: nack at ninth rise, or rise/next fall by clock delay.
// [RULE12] Receive event: ack at ninth rise, or ninth falling edge in mode one.
// [RULE13] Software writes zero to every bit without a two-wire function.
// [RULE14] Data output is always open-drain; no open-drain select bit exists.
// [RULE15] Software writes zero to bits 4 and 5 of control register 1.
// [RULE16] Software clears flow-control disable and direction on channel 1 here.
// [RULE17] Software routes factor select bits to bus collision for channels 0, 1.
// [RULE18] Software clears pending flags after changing mode or interrupt-timing bits.
// [RULE19] A condition request bit clears itself once its condition is done.
module scic_channel
    import scic_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // register port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // bus lines, open-drain
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // interrupt
    output logic irq_o
);

    scic_state_t q;
    scic_state_t d;

    logic i2c_on;
    logic cond_en;
    logic im;
    logic clock_delay_select;
    logic [2:0] dl;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic nine_rise;
    logic nine_fall;
    logic ev_tx;
    logic ev_rx;
    logic [7:0] st_set;
    logic [7:0] st_clr;
    logic mr4_wr;
    logic cg_done;
    logic launch;
    logic gen_sda;
    logic gen_scl;
    logic ack_pull;
    logic pull_now;

    // decoded settings
    always_comb begin
        i2c_on = (q.mode[MODE_SMD_LSB +: 3] == SMD_I2C) && q.mode[MODE_TWO_WIRE_ENABLE]; // [RULE9]
        cond_en = i2c_on && q.mr4[MR4_CSEL]; // [RULE4]
        im = q.mode[MODE_IM];
        clock_delay_select = q.mr3[MR3_CLOCK_DELAY_SELECT];
        dl = q.mr3[MR3_DL_LSB +: 3];
        mr4_wr = wr_i && (addr_i == A_MR4);
    end

    // line events; only the second sync stage and later are looked at
    always_comb begin
        scl_rise = q.s2.scl && !q.prev.scl;
        scl_fall = !q.s2.scl && q.prev.scl;
        start_det = q.s2.scl && q.prev.scl && q.prev.sda && !q.s2.sda;
        stop_det = q.s2.scl && q.prev.scl && !q.prev.sda && q.s2.sda;
        nine_rise = scl_rise && (q.bitcnt == BIT_EIGHT);
        nine_fall = scl_fall && (q.bitcnt == BIT_NINE);
    end

    // event sources, all gated by two-wire mode
    always_comb begin
        if (!im) begin
            ev_tx = nine_rise && q.s2.sda; // [RULE11]
            ev_rx = nine_rise && !q.s2.sda; // [RULE12]
        end else begin
            // clock delay moves the transmit event to the ninth falling edge
            ev_tx = clock_delay_select ? nine_fall : nine_rise; // [RULE11]
            ev_rx = nine_fall; // [RULE12]
        end
        st_set = 8'h00;
        st_set[ST_START] = i2c_on && start_det; // [RULE10]
        st_set[ST_STOP] = i2c_on && stop_det;
        st_set[ST_TX] = i2c_on && ev_tx;
        st_set[ST_RX] = i2c_on && ev_rx;
        st_clr = (wr_i && (addr_i == A_STAT)) ? wdata_i : 8'h00;
    end

    // condition generator drive per state
    always_comb begin
        gen_sda = 1'b0;
        gen_scl = 1'b0;
        case (q.cg)
            CG_IDLE: begin
                gen_sda = 1'b0;
            end
            CG_PREP: begin
                // stop starts from data low, clock low
                gen_sda = (q.kind == K_STOP); // [RULE3]
                gen_scl = (q.kind == K_STOP);
            end
            CG_MID: begin
                // data low while clock released: start edge or stop setup
                gen_sda = 1'b1; // [RULE1] [RULE2]
            end
            CG_LAST: begin
                gen_sda = (q.kind != K_STOP);
                gen_scl = (q.kind != K_STOP);
            end
            default: begin
                gen_sda = 1'b0;
            end
        endcase
        cg_done = (q.cg == CG_LAST) && (q.cnt == '0) && cond_en;
        launch = (q.cg == CG_IDLE) && cond_en
            && (q.mr4[MR4_START] || q.mr4[MR4_RESTART] || q.mr4[MR4_STOP]);
        // low acknowledge_value means ack, pulled low
        ack_pull = q.ack_win && q.mr4[MR4_ACKNOWLEDGE_OUTPUT] && !q.mr4[MR4_ACKNOWLEDGE_VALUE]; // [RULE5]
        pull_now = gen_sda || ack_pull;
    end

    // next state
    always_comb begin
        d = q;
        // two-stage synchroniser, then one stage for edges
        d.s1 = '{scl: scl_i, sda: sda_i};
        d.s2 = q.s1;
        d.prev = q.s2;

        // bit counter restarts on start and after each ninth clock
        if (start_det || nine_fall) begin
            d.bitcnt = 4'h0;
        end else if (scl_rise && (q.bitcnt != BIT_NINE)) begin
            d.bitcnt = q.bitcnt + 4'h1;
        end

        // acknowledge slot spans eighth falling to ninth falling edge
        if (start_det || nine_fall) begin
            d.ack_win = 1'b0;
        end else if (scl_fall && (q.bitcnt == BIT_EIGHT)) begin
            d.ack_win = 1'b1;
        end

        // sticky flags; a new event beats a clear in the same cycle
        d.stat = (q.stat & ~st_clr) | st_set;

        // plain registers
        if (wr_i) begin
            case (addr_i)
                A_MODE: d.mode = wdata_i;
                A_MR3: d.mr3 = wdata_i;
                A_MASK: d.mask = wdata_i;
                A_COMMON: d.common = wdata_i;
                A_IFSR: d.ifsr = wdata_i;
                default: d.mode = q.mode;
            endcase
        end

        // request bits clear when done; a write in that cycle still wins
        if (cg_done) begin
            case (q.kind)
                K_START: d.mr4[MR4_START] = 1'b0; // [RULE19]
                K_RESTART: d.mr4[MR4_RESTART] = 1'b0; // [RULE19]
                K_STOP: d.mr4[MR4_STOP] = 1'b0; // [RULE19]
                default: d.mr4 = q.mr4;
            endcase
        end
        if (mr4_wr) begin
            d.mr4 = wdata_i;
        end

        // condition sequencer; dropping the select aborts it
        case (q.cg)
            CG_IDLE: begin
                if (launch) begin
                    d.cg = CG_PREP;
                    d.cnt = COND_LOAD;
                    if (q.mr4[MR4_START]) begin
                        d.kind = K_START; // [RULE1]
                    end else if (q.mr4[MR4_RESTART]) begin
                        d.kind = K_RESTART; // [RULE2]
                    end else begin
                        d.kind = K_STOP; // [RULE3]
                    end
                end
            end
            CG_PREP, CG_MID, CG_LAST: begin
                if (!cond_en) begin
                    d.cg = CG_IDLE; // [RULE4]
                end else if (q.cnt != '0) begin
                    d.cnt = q.cnt - 1'b1;
                end else begin
                    d.cnt = COND_LOAD;
                    case (q.cg)
                        CG_PREP: d.cg = CG_MID;
                        CG_MID: d.cg = CG_LAST;
                        default: d.cg = CG_IDLE;
                    endcase
                end
            end
            default: begin
                d.cg = CG_IDLE;
            end
        endcase

        // ninth-clock hold lasts until software drops the bit
        if (!q.mr4[MR4_HOLD9]) begin
            d.hold = 1'b0;
        end else if (nine_fall) begin
            d.hold = 1'b1; // [RULE7]
        end

        // clock silenced after a stop until the next launched condition
        if (launch) begin
            d.stop_off = 1'b0;
        end else if (stop_det && q.mr4[MR4_CLOCK_STOP_ON_STOP]) begin
            d.stop_off = 1'b1; // [RULE6]
        end

        // data delay line; tap zero still costs the output register
        d.pipe = {q.pipe[6:0], pull_now};
        d.sda_oe_n = !d.pipe[dl]; // [RULE8] [RULE14]
        d.scl_oe_n = !((d.hold || gen_scl) && !d.stop_off); // [RULE6] [RULE7]
        d.irq = |(d.stat & d.mask);

        // read data valid only in the cycle after the strobe
        d.rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                A_MODE: d.rdata = q.mode;
                A_MR3: d.rdata = q.mr3;
                A_MR4: d.rdata = q.mr4;
                A_STAT: d.rdata = q.stat;
                A_MASK: d.rdata = q.mask;
                A_LINE: d.rdata = {q.bitcnt, 1'b0, q.hold, q.s2.sda, q.s2.scl};
                A_COMMON: d.rdata = q.common;
                A_IFSR: d.rdata = q.ifsr;
                default: d.rdata = 8'h00;
            endcase
        end
    end

    // state register; lines idle high after reset
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q.s1 <= '{scl: 1'b1, sda: 1'b1};
            q.s2 <= '{scl: 1'b1, sda: 1'b1};
            q.prev <= '{scl: 1'b1, sda: 1'b1};
            q.mode <= REG_RST;
            q.mr3 <= REG_RST;
            q.mr4 <= REG_RST;
            q.stat <= REG_RST;
            q.mask <= REG_RST;
            q.common <= REG_RST;
            q.ifsr <= REG_RST;
            q.rdata <= REG_RST;
            q.bitcnt <= 4'h0;
            q.ack_win <= 1'b0;
            q.hold <= 1'b0;
            q.stop_off <= 1'b0;
            q.cg <= CG_IDLE;
            q.kind <= K_START;
            q.cnt <= '0;
            q.pipe <= 8'h00;
            q.scl_oe_n <= 1'b1;
            q.sda_oe_n <= 1'b1;
            q.irq <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register; open-drain drives low only
    assign rdata_o = q.rdata;
    assign scl_o = q.pipe[7] & 1'b0;
    assign sda_o = q.pipe[7] & 1'b0;
    assign scl_oe_n_o = q.scl_oe_n;
    assign sda_oe_n_o = q.sda_oe_n;
    assign irq_o = q.irq;

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    logic dl_zero;
    assign dl_zero = (dl == 3'h0);

    sequence s_cg_done;
        (q.cg == CG_LAST) && (q.cnt == '0) && cond_en && !mr4_wr;
    endsequence

    sequence s_hold_cause;
        nine_fall && q.mr4[MR4_HOLD9] && !mr4_wr && !q.stop_off && !stop_det;
    endsequence

    a_start_flag: assert property (i2c_on && start_det |=> q.stat[ST_START]) // [RULE10]
        else $error("start detect did not set its flag");
    a_mode_gate: assert property (!i2c_on |=> (q.stat & ~$past(q.stat)) == 8'h00) // [RULE9]
        else $error("event raised outside two-wire mode");
    a_cond_select: assert property ((q.cg != CG_IDLE) |-> ##1 ($past(cond_en) || q.cg == CG_IDLE)) // [RULE4]
        else $error("condition kept running without select");
    a_req_clear: assert property (s_cg_done and (q.kind == K_STOP) |=> !q.mr4[MR4_STOP]) // [RULE19]
        else $error("stop request not cleared after completion");
    a_start_wave: assert property ((q.cg == CG_MID) && (q.kind == K_START) && cond_en
        |-> ##1 !$past(gen_scl) && $past(gen_sda)) // [RULE1]
        else $error("start middle phase wrong");
    a_hold_nine: assert property (s_hold_cause |=> q.hold ##1 !scl_oe_n_o) // [RULE7]
        else $error("ninth clock hold not applied");
    a_stop_quiet: assert property (q.stop_off |-> scl_oe_n_o) // [RULE6]
        else $error("clock driven after stop with stop-hold set");
    a_ack_drive: assert property (ack_pull && dl_zero |=> !sda_oe_n_o) // [RULE5]
        else $error("ack not driven low");
    a_data_delay: assert property ($past(dl_zero) |-> sda_oe_n_o == !$past(pull_now)) // [RULE8]
        else $error("data delay zero path wrong");
    a_tx_nack: assert property (i2c_on && !im && nine_rise && q.s2.sda |=> q.stat[ST_TX]) // [RULE11]
        else $error("nack transmit event missing");
    a_rx_fall: assert property (i2c_on && im && nine_fall |=> q.stat[ST_RX]) // [RULE12]
        else $error("receive event at ninth fall missing");
    a_irq_level: assert property (irq_o == |(q.stat & q.mask))
        else $error("interrupt level disagrees with flags");

endmodule
`default_nettype wire

// [core/scic_pkg.sv]
// package: constants, map and types of the two-wire channel control block
package scic_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int COND_HOLD_NS = 600;
    localparam int COND_HOLD_CYC = (COND_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] COND_LOAD = CNT_W'(COND_HOLD_CYC - 1);

    // register map, one byte per index
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] A_MODE = 4'h0;
    localparam logic [ADDR_W-1:0] A_MR3 = 4'h1;
    localparam logic [ADDR_W-1:0] A_MR4 = 4'h2;
    localparam logic [ADDR_W-1:0] A_STAT = 4'h3;
    localparam logic [ADDR_W-1:0] A_MASK = 4'h4;
    localparam logic [ADDR_W-1:0] A_LINE = 4'h5;
    localparam logic [ADDR_W-1:0] A_COMMON = 4'h6;
    localparam logic [ADDR_W-1:0] A_IFSR = 4'h7;
    localparam logic [7:0] REG_RST = 8'h00;

    // mode register fields
    localparam int MODE_SMD_LSB = 0;
    localparam int MODE_TWO_WIRE_ENABLE = 3;
    localparam int MODE_IM = 4;
    localparam logic [2:0] SMD_I2C = 3'h2;
    localparam logic [2:0] SMD_SYNC = 3'h1;
    // i2c_mode_register_3 fields
    localparam int MR3_CLOCK_DELAY_SELECT = 1;
    localparam int MR3_DL_LSB = 5;
    // i2c_mode_register_4 fields
    localparam int MR4_START = 0;
    localparam int MR4_RESTART = 1;
    localparam int MR4_STOP = 2;
    localparam int MR4_CSEL = 3;
    localparam int MR4_ACKNOWLEDGE_VALUE = 4;
    localparam int MR4_ACKNOWLEDGE_OUTPUT = 5;
    localparam int MR4_CLOCK_STOP_ON_STOP = 6;
    localparam int MR4_HOLD9 = 7;
    // status and mask fields
    localparam int ST_START = 0;
    localparam int ST_STOP = 1;
    localparam int ST_TX = 2;
    localparam int ST_RX = 3;
    // bit counter marks
    localparam logic [3:0] BIT_EIGHT = 4'h8;
    localparam logic [3:0] BIT_NINE = 4'h9;

    typedef enum logic [1:0] {CG_IDLE, CG_PREP, CG_MID, CG_LAST} scic_cg_t;
    typedef enum logic [1:0] {K_START, K_RESTART, K_STOP} scic_kind_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } scic_lines_t;

    typedef struct packed {
        scic_lines_t s1;
        scic_lines_t s2;
        scic_lines_t prev;
        logic [7:0] mode;
        logic [7:0] mr3;
        logic [7:0] mr4;
        logic [7:0] stat;
        logic [7:0] mask;
        logic [7:0] common;
        logic [7:0] ifsr;
        logic [7:0] rdata;
        logic [3:0] bitcnt;
        logic ack_win;
        logic hold;
        logic stop_off;
        scic_cg_t cg;
        scic_kind_t kind;
        logic [CNT_W-1:0] cnt;
        logic [7:0] pipe;
        logic scl_oe_n;
        logic sda_oe_n;
        logic irq;
    } scic_state_t;
endpackage

// [testbench/scic_bus_model.sv]
// bus model: another two-wire master clocking bytes at a 125 ns bit period
`timescale 1ns/1ps
`default_nettype none
module scic_bus_model (
    // wire levels seen on the bus
    input wire logic sda_w_i,
    // open-drain pulls, one means pulling low
    output logic scl_pull_o,
    output logic sda_pull_o
);
    // idle: both released, pull-ups hold the lines high
    initial begin
        scl_pull_o = 1'b0;
        sda_pull_o = 1'b0;
    end
    // start: data falls while the clock is high
    task automatic start_c();
        sda_pull_o = 1'b1;
        #62.5 scl_pull_o = 1'b1;
        #31.25;
    endtask
    // stop: data rises while the clock is high
    task automatic stop_c();
        sda_pull_o = 1'b1;
        #31.25 scl_pull_o = 1'b0;
        #62.5 sda_pull_o = 1'b0;
        #62.5;
    endtask
    // eight data bits, msb first, then the ninth rise; clock left high
    task automatic byte_c(input logic [7:0] d, input logic rel9, output logic s9);
        for (int i = 7; i >= 0; i--) begin
            sda_pull_o = ~d[i];
            #31.25 scl_pull_o = 1'b0;
            #62.5 scl_pull_o = 1'b1;
            #31.25;
        end
        // released data lets the channel place its acknowledge
        sda_pull_o = ~rel9;
        #31.25 scl_pull_o = 1'b0;
        #31.25 s9 = sda_w_i;
        #31.25;
    endtask
    // ninth falling edge, data released afterwards
    task automatic fall9();
        scl_pull_o = 1'b1;
        #31.25 sda_pull_o = 1'b0;
        #31.25;
    endtask
endmodule
`default_nettype wire

// [testbench/tb_scic_channel.sv]
// testbench of the two-wire channel control block
`timescale 1ns/1ps
`default_nettype none
module tb_scic_channel;
    import scic_pkg::*;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, irq_o;
    logic p_scl, p_sda, scl_w, sda_w;
    int error_cnt = 0;
    int checks_done = 0;
    // wired-and of both parties, pull-ups make released lines high
    assign scl_w = ~p_scl & (scl_oe_n_o | scl_o);
    assign sda_w = ~p_sda & (sda_oe_n_o | sda_o);
    scic_channel i_scic_channel (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n_o), .irq_o(irq_o));
    scic_bus_model i_scic_bus_model (.sda_w_i(sda_w), .scl_pull_o(p_scl), .sda_pull_o(p_sda));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask
    // bus cycles: strobes rise after an edge and drop at the next one
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1; addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp, what);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic too_long();
        error_cnt++;
        $display("unexpected at %0t: wait ran out", $time);
        print_verdict();
    endtask
    // reset values, storage, read-only and unmapped places
    task automatic t_regs();
        for (int a = 0; a < 8; a++) rchk(a[3:0], (a == 5) ? 8'h03 : REG_RST, "reset value");
        // undefined mode bits and flow-control related bits are written as zero
        wr(A_MR3, 8'he2); wr(A_COMMON, 8'h00); wr(A_IFSR, 8'hc0);
        rchk(A_MR3, 8'he2, "mr3 store");
        rchk(A_IFSR, 8'hc0, "ifsr store");
        wr(A_LINE, 8'hf0); rchk(A_LINE, 8'h03, "line ro");
        wr(4'h9, 8'h5a); rchk(4'h9, 8'h00, "unmapped");
        wr(A_MR3, 8'h00);
    endtask
    // start detection only in two-wire mode, sticky, masked, w1c
    task automatic t_start_evt();
        logic [7:0] modes [4] = '{8'h01, 8'h02, 8'h09, 8'h0a};
        logic s;
        for (int m = 0; m < 4; m++) begin
            wr(A_MODE, modes[m]); wr(A_STAT, 8'hff);
            i_scic_bus_model.start_c();
            i_scic_bus_model.byte_c(8'ha5, 1'b1, s);
            i_scic_bus_model.fall9();
            i_scic_bus_model.stop_c();
            idle(10);
            rchk(A_STAT, (m == 3) ? 8'h07 : 8'h00, "start event by mode");
        end
        chk(irq_o, 1'b0, "masked irq");
        wr(A_MASK, 8'h01); idle(2); chk(irq_o, 1'b1, "unmasked irq");
        wr(A_STAT, 8'h01); idle(2); chk(irq_o, 1'b0, "cleared irq");
        rchk(A_STAT, 8'h06, "w1c other bits kept");
        wr(A_MASK, 8'h00);
    endtask
    // acknowledge drive and ninth-rise events with interrupt mode zero
    task automatic t_ack();
        logic s;
        for (int v = 0; v < 2; v++) begin
            wr(A_MR4, v ? 8'h30 : 8'h20); wr(A_STAT, 8'hff);
            i_scic_bus_model.start_c();
            i_scic_bus_model.byte_c(8'h3c, 1'b1, s);
            chk(s, v[0], "ack value on wire");
            i_scic_bus_model.fall9();
            i_scic_bus_model.stop_c();
            idle(10);
            rchk(A_STAT, v ? 8'h07 : 8'h0b, "nack tx or ack rx");
        end
        wr(A_MR4, 8'h00);
    endtask
    // interrupt mode one: rise or fall timing by clock delay
    task automatic t_im1();
        logic s;
        for (int k = 0; k < 2; k++) begin
            wr(A_MODE, 8'h1a); wr(A_MR3, k ? 8'h02 : 8'h00); wr(A_STAT, 8'hff);
            i_scic_bus_model.start_c();
            i_scic_bus_model.byte_c(8'h81, 1'b0, s);
            rchk(A_STAT, k ? 8'h01 : 8'h05, "events at ninth rise");
            i_scic_bus_model.fall9();
            idle(10);
            rchk(A_STAT, 8'h0d, "events at ninth fall");
            i_scic_bus_model.stop_c();
        end
        wr(A_MODE, 8'h0a); wr(A_MR3, 8'h00); wr(A_STAT, 8'hff);
    endtask
    // clock held low from the ninth fall until the bit is cleared
    task automatic t_hold();
        logic s;
        wr(A_MR4, 8'h80);
        i_scic_bus_model.start_c();
        i_scic_bus_model.byte_c(8'h11, 1'b0, s);
        i_scic_bus_model.fall9();
        i_scic_bus_model.scl_pull_o = 1'b0;
        idle(50);
        chk(scl_oe_n_o, 1'b0, "clock held");
        rchk(A_LINE, 8'h06, "hold flag, count cleared");
        wr(A_MR4, 8'h00); idle(3);
        chk(scl_oe_n_o, 1'b1, "hold released");
        i_scic_bus_model.stop_c();
        wr(A_STAT, 8'hff);
    endtask
    // wait until a request bit has cleared itself
    task automatic wait_req(input int b);
        logic [7:0] d;
        for (int i = 0; i < 100; i++) begin
            rd(A_MR4, d);
            if (d[b] === 1'b0) return;
        end
        too_long();
    endtask
    // generated conditions, refusal, data delay, self-clearing requests
    task automatic t_cond(input logic [2:0] dl);
        int gap;
        wr(A_MR3, {dl, 5'h00});
        wr(A_MR4, 8'h01); idle(100);
        chk({scl_oe_n_o, sda_oe_n_o}, 2'b11, "no drive without select");
        rchk(A_MR4, 8'h01, "request kept");
        wr(A_MR4, 8'h09);
        for (gap = 0; gap < 300 && sda_oe_n_o !== 1'b0; gap++) idle(1);
        if (gap == 300) too_long();
        chk(scl_oe_n_o, 1'b1, "clock high during start");
        for (gap = 0; gap < 300 && scl_oe_n_o !== 1'b0; gap++) idle(1);
        chk(gap[7:0], 8'(COND_HOLD_CYC - dl), "data delay");
        chk({scl_o, sda_o}, 2'b00, "open-drain drive");
        wait_req(MR4_START);
        // data release trails the clock release by the delay taps
        idle(10);
        chk({scl_oe_n_o, sda_oe_n_o}, 2'b11, "released after start");
        wr(A_MR4, 8'h0a); wait_req(MR4_RESTART);
        // a delayed data release after the clock reads as a stop on the bus
        rchk(A_STAT, (dl == 3'h0) ? 8'h01 : 8'h03, "start seen on bus");
        wr(A_STAT, 8'hff);
        wr(A_MR4, 8'h0c); wait_req(MR4_STOP);
        idle(5);
        rchk(A_STAT, 8'h02, "stop seen on bus");
        wr(A_MR4, 8'h00); wr(A_STAT, 8'hff);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        chk({scl_oe_n_o, sda_oe_n_o, irq_o}, 3'b110, "reset outputs");
        t_regs();
        t_start_evt();
        t_ack();
        t_im1();
        t_hold();
        t_cond(3'h0);
        t_cond(3'h7);
        print_verdict();
    end
endmodule
`default_nettype wire
